//--- rtl/brw_boot_wake.sv
// Reset-exit boot sequencer: reads the configuration record and boot header,
// then hands start addresses and wake enables to the processor cores.
// Assumes a flash read port that flags each answer with i_rd_valid, after any delay.
`timescale 1ns/1ps
`default_nettype none
module brw_boot_wake (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_reset_seq_done,
  input  wire logic [31:0] i_cfg_boot_vector,
  input  wire logic        i_cfg_assist_en,
  input  wire logic        i_cfg_security_en,
  input  wire logic [31:0] i_assist_base,
  input  wire logic [31:0] i_assist_size,
  output logic             o_rd_req,
  output logic [31:0]      o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output logic [2:0]       o_core_wake,
  output logic [95:0]      o_core_start_addr,
  output logic             o_security_wake,
  output logic             o_func_idle,
  output logic             o_boot_fail
);
  import brw_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  brw_state_t  state_ff,   nxt_state;
  logic [31:0] base_ff,    nxt_base;
  logic [31:0] boot_ff,    nxt_boot;
  logic [31:0] c0_ff,      nxt_c0;
  logic [31:0] c1_ff,      nxt_c1;
  logic [2:0]  en_ff,      nxt_en;
  logic        assist_ff,  nxt_assist;
  logic        sec_ff,     nxt_sec;
  logic        tag_ok;
  logic [2:0]  tag_en;

  // Range test applied to the configured boot vector only
  function automatic logic in_assist(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] s);
    in_assist = (a >= b) && ((a - b) < s);
  endfunction

  brw_hdr_check u_hdr (
    .i_word    (i_rd_data),
    .i_strict  (assist_ff),
    .o_tag_ok  (tag_ok),
    .o_enables (tag_en)
  );

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_base   = base_ff;
    nxt_boot   = boot_ff;
    nxt_c0     = c0_ff;
    nxt_c1     = c1_ff;
    nxt_en     = en_ff;
    nxt_assist = assist_ff;
    nxt_sec    = sec_ff;
    case (state_ff)
      BRW_SEQ_RESET: begin
        if (i_reset_seq_done) begin
          nxt_state = BRW_SEQ_CFG_RD;
        end
      end
      BRW_SEQ_CFG_RD: begin
        // Straps caught after release, never under the async reset
        nxt_assist = i_cfg_assist_en;
        nxt_sec    = i_cfg_security_en;
        nxt_base   = i_cfg_boot_vector;
        if (in_assist(i_cfg_boot_vector, i_assist_base, i_assist_size)) begin
          nxt_state = BRW_SEQ_TAG_RD;
        end else begin
          nxt_state = BRW_SEQ_FAIL;
        end
      end
      BRW_SEQ_TAG_RD: begin
        if (i_rd_valid) begin
          if (tag_ok) begin
            // Direct boot: boot processor only
            nxt_en    = assist_ff ? tag_en : 3'b001;
            nxt_state = BRW_SEQ_VEC_RD;
          end else begin
            nxt_state = BRW_SEQ_FAIL;
          end
        end
      end
      BRW_SEQ_VEC_RD: begin
        if (i_rd_valid) begin
          nxt_boot  = i_rd_data;
          nxt_state = assist_ff ? BRW_SEQ_AUX_RD : BRW_SEQ_WAKE;
        end
      end
      BRW_SEQ_AUX_RD: begin
        // Two reads: core 0 then core 1, told apart by the address in flight
        if (i_rd_valid) begin
          if (o_rd_addr == base_ff + BRW_OFS_VEC_C0) begin
            nxt_c0 = i_rd_data;
          end else begin
            nxt_c1    = i_rd_data;
            nxt_state = BRW_SEQ_WAKE;
          end
        end
      end
      BRW_SEQ_WAKE: begin
        nxt_state = BRW_SEQ_IDLE;
      end
      BRW_SEQ_IDLE: begin
        nxt_state = BRW_SEQ_IDLE;
      end
      BRW_SEQ_FAIL: begin
        nxt_state = BRW_SEQ_FAIL;
      end
      default: begin
        nxt_state = BRW_SEQ_FAIL;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff  <= BRW_SEQ_RESET;
      base_ff   <= 32'h0000_0000;
      boot_ff   <= 32'h0000_0000;
      c0_ff     <= 32'h0000_0000;
      c1_ff     <= 32'h0000_0000;
      en_ff     <= 3'h0;
      assist_ff <= 1'b0;
      sec_ff    <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      base_ff   <= nxt_base;
      boot_ff   <= nxt_boot;
      c0_ff     <= nxt_c0;
      c1_ff     <= nxt_c1;
      en_ff     <= nxt_en;
      assist_ff <= nxt_assist;
      sec_ff    <= nxt_sec;
    end
  end

  // ----------------------------------------
  // Read address sequencing
  // ----------------------------------------
  logic [31:0] addr_ff, nxt_addr;
  logic        req_ff,  nxt_req;

  // One request in flight; next issued the cycle after data returns
  always_comb begin
    nxt_addr = addr_ff;
    nxt_req  = 1'b0;
    case (nxt_state)
      BRW_SEQ_TAG_RD: begin
        nxt_addr = nxt_base + BRW_OFS_TAG;
        nxt_req  = (state_ff != BRW_SEQ_TAG_RD);
      end
      BRW_SEQ_VEC_RD: begin
        nxt_addr = base_ff + BRW_OFS_VEC_BOOT;
        nxt_req  = (state_ff != BRW_SEQ_VEC_RD);
      end
      BRW_SEQ_AUX_RD: begin
        if (state_ff != BRW_SEQ_AUX_RD) begin
          nxt_addr = base_ff + BRW_OFS_VEC_C0;
          nxt_req  = 1'b1;
        end else if (i_rd_valid) begin
          nxt_addr = base_ff + BRW_OFS_VEC_C1;
          nxt_req  = 1'b1;
        end
      end
      default: begin
        nxt_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_ff <= 32'h0000_0000;
      req_ff  <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      req_ff  <= nxt_req;
    end
  end

  assign o_rd_req  = req_ff;
  assign o_rd_addr = addr_ff;

  // ----------------------------------------
  // Wake outputs
  // ----------------------------------------
  logic [2:0]  wake_ff, nxt_wake;
  logic [95:0] sa_ff,   nxt_sa;
  logic        secw_ff, nxt_secw;

  // Held until wake; boot core always woken, disabled cores 0 and 1 stay in reset with zero address
  always_comb begin
    nxt_wake = wake_ff;
    nxt_sa   = sa_ff;
    nxt_secw = secw_ff;
    if (state_ff == BRW_SEQ_WAKE) begin
      nxt_wake[BRW_BOOT_CORE] = 1'b1;
      nxt_sa[BRW_BOOT_CORE*32 +: 32] = boot_ff;
      nxt_wake[0] = en_ff[BRW_EN_C0_BIT];
      nxt_wake[1] = en_ff[BRW_EN_C1_BIT];
      nxt_sa[31:0]  = en_ff[BRW_EN_C0_BIT] ? c0_ff : 32'h0000_0000;
      nxt_sa[63:32] = en_ff[BRW_EN_C1_BIT] ? c1_ff : 32'h0000_0000;
      nxt_secw = sec_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_ff <= 3'h0;
      sa_ff   <= 96'h0;
      secw_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
      sa_ff   <= nxt_sa;
      secw_ff <= nxt_secw;
    end
  end

  assign o_core_wake       = wake_ff;
  assign o_core_start_addr = sa_ff;
  assign o_security_wake   = secw_ff;
  assign o_func_idle       = (state_ff == BRW_SEQ_IDLE);
  assign o_boot_fail       = (state_ff == BRW_SEQ_FAIL);
endmodule
`default_nettype wire

//--- rtl/brw_pkg.sv
// Constants for the reset-exit boot and core wake block.
// Assumes a 32-bit byte-addressed configuration flash read port.
package brw_pkg;

  // ----------------------------------------
  // Record layout
  // ----------------------------------------
  localparam logic [31:0] BRW_OFS_TAG      = 32'h0000_0000;
  localparam logic [31:0] BRW_OFS_VEC_BOOT = 32'h0000_0004;
  localparam logic [31:0] BRW_OFS_VEC_C0   = 32'h0000_0008;
  localparam logic [31:0] BRW_OFS_VEC_C1   = 32'h0000_000c;
  localparam logic [7:0]  BRW_TAG_VALUE    = 8'ha5;
  localparam int          BRW_TAG_LSB      = 16;
  localparam int          BRW_EN_BOOT_BIT  = 0;
  localparam int          BRW_EN_C0_BIT    = 1;
  localparam int          BRW_EN_C1_BIT    = 2;
  localparam int          BRW_ZERO_LSB     = 3;
  localparam int          BRW_ZERO_MSB     = 15;

  // ----------------------------------------
  // Core numbering: boot processor is core two
  // ----------------------------------------
  localparam int          BRW_NUM_CORES    = 3;
  localparam int          BRW_BOOT_CORE    = 2;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [7:0] {
    BRW_SEQ_RESET   = 8'h01,
    BRW_SEQ_CFG_RD  = 8'h02,
    BRW_SEQ_TAG_RD  = 8'h04,
    BRW_SEQ_VEC_RD  = 8'h08,
    BRW_SEQ_AUX_RD  = 8'h10,
    BRW_SEQ_WAKE    = 8'h20,
    BRW_SEQ_IDLE    = 8'h40,
    BRW_SEQ_FAIL    = 8'h80
  } brw_state_t;

endpackage

//--- rtl/brw_hdr_check.sv
// Boot header tag checker.
// Assumes a word read back from flash in the same clock cycle it is held.
`timescale 1ns/1ps
`default_nettype none
module brw_hdr_check (
  input  wire logic [31:0] i_word,
  input  wire logic        i_strict,
  output logic             o_tag_ok,
  output logic [2:0]       o_enables
);
  import brw_pkg::*;

  // ----------------------------------------
  // Tag and flag decode
  // ----------------------------------------
  // Flags counted 31..29 from the MSB-0 end land on bits 0..2 here
  always_comb begin
    o_tag_ok  = (i_word[BRW_TAG_LSB +: 8] == BRW_TAG_VALUE);
    if (i_strict && (i_word[BRW_ZERO_MSB:BRW_ZERO_LSB] != 13'h0000)) begin
      o_tag_ok = 1'b0;
    end
    o_enables = i_word[BRW_EN_C1_BIT:BRW_EN_BOOT_BIT];
  end
endmodule
`default_nettype wire

//--- verif/brw_flash_model.sv
// Flash read port model holding one four-word boot record.
// Assumes one read outstanding; answer delay set by i_wait.
`timescale 1ns/1ps
`default_nettype none
module brw_flash_model (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_rd_req,
  input  wire logic [31:0]  i_rd_addr,
  input  wire logic [127:0] i_words,
  input  wire logic [1:0]   i_wait,
  output logic [31:0]       o_rd_data,
  output logic              o_rd_valid
);
  // ----------------------------------------
  // Answer logic
  // ----------------------------------------
  logic [2:0]  cnt_ff;
  logic [2:0]  nxt_cnt;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic        vld_ff;
  logic        nxt_vld;
  // Idle data toggles so a stale word is never mistaken for an answer
  always_comb begin
    nxt_cnt = (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
    nxt_vld = (cnt_ff == 3'h1);
    nxt_dat = nxt_vld ? i_words[{i_rd_addr[3:2], 5'h00} +: 32] : ~dat_ff;
    if (i_rd_req) begin
      nxt_cnt = {1'b0, i_wait} + 3'h1;
    end
  end
  // Registers only
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= 3'h0;
      vld_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      vld_ff <= nxt_vld;
      dat_ff <= nxt_dat;
    end
  end
  assign o_rd_data  = dat_ff;
  assign o_rd_valid = vld_ff;
endmodule
`default_nettype wire

//--- verif/brw_boot_wake_assertions.sv
// Checker for the boot and core wake sequencer.
// Assumes the top module's ports only; bound below.
`timescale 1ns/1ps
`default_nettype none
module brw_boot_wake_assertions (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic [31:0] i_cfg_boot_vector,
  input wire logic        i_cfg_assist_en,
  input wire logic        i_cfg_security_en,
  input wire logic        o_rd_req,
  input wire logic [31:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic        i_rd_valid,
  input wire logic [2:0]  o_core_wake,
  input wire logic [95:0] o_core_start_addr,
  input wire logic        o_security_wake,
  input wire logic        o_func_idle,
  input wire logic        o_boot_fail
);
  // ----------------------------------------
  // Read tracking
  // ----------------------------------------
  logic        seen_ff;
  logic [31:0] last_ff;
  logic [1:0]  nv_ff;
  logic [31:0] vec_ff;
  // Answer count tells the tag word from the vector words
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seen_ff <= 1'b0;
      last_ff <= 32'h0;
      nv_ff   <= 2'h0;
      vec_ff  <= 32'h0;
    end else begin
      seen_ff <= seen_ff | o_rd_req;
      last_ff <= o_rd_req ? o_rd_addr : last_ff;
      nv_ff   <= nv_ff + {1'b0, i_rd_valid};
      vec_ff  <= (i_rd_valid && nv_ff == 2'h1) ? i_rd_data : vec_ff;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_boot_core; o_core_wake != 3'h0 |-> o_core_wake[2]; endproperty
  a_boot_core: assert property (p_boot_core) else $error("wake without boot core");
  property p_sec; $rose(o_core_wake[2]) |-> o_security_wake == i_cfg_security_en; endproperty
  a_sec: assert property (p_sec) else $error("security wake wrong");
  property p_idle; $rose(o_func_idle) |-> o_core_wake[2] && !o_boot_fail; endproperty
  a_idle: assert property (p_idle) else $error("idle without boot core");
  property p_first; o_rd_req && !seen_ff |-> o_rd_addr == i_cfg_boot_vector; endproperty
  a_first: assert property (p_first) else $error("first read address");
  property p_next; o_rd_req && seen_ff |-> o_rd_addr == last_ff + 32'h4; endproperty
  a_next: assert property (p_next) else $error("read address step");
  property p_pulse; o_rd_req |=> !o_rd_req; endproperty
  a_pulse: assert property (p_pulse) else $error("read request too long");
  property p_tag; i_rd_valid && nv_ff == 2'h0 && i_rd_data[23:16] != 8'ha5 |-> ##[1:3] o_boot_fail;
  endproperty
  a_tag: assert property (p_tag) else $error("bad tag accepted");
  property p_direct; o_func_idle && !i_cfg_assist_en |->
    o_core_wake == 3'h4 && o_core_start_addr[95:64] == vec_ff; endproperty
  a_direct: assert property (p_direct) else $error("direct boot result");
  property p_off; o_core_start_addr[31:0] != 32'h0 || o_core_start_addr[63:32] != 32'h0
    |-> (o_core_start_addr[31:0] == 32'h0 || o_core_wake[0])
    && (o_core_start_addr[63:32] == 32'h0 || o_core_wake[1]); endproperty
  a_off: assert property (p_off) else $error("address for sleeping core");
  property p_hold; o_func_idle |=> $stable(o_core_wake) && $stable(o_core_start_addr); endproperty
  a_hold: assert property (p_hold) else $error("wake state moved");
endmodule
bind brw_boot_wake brw_boot_wake_assertions brw_boot_wake_assertions_inst (.*);
`default_nettype wire

//--- verif/brw_boot_wake_test.sv
// Self-checking bench for the boot and core wake sequencer.
// Assumes the flash model as the read port partner.
`timescale 1ns/1ps
`default_nettype none
module brw_boot_wake_test;
  localparam logic [31:0] VEC = 32'h0000_1010;
  localparam logic [31:0] SA  = 32'h0000_1200;
  localparam logic [31:0] C0  = 32'h0000_1300;
  localparam logic [31:0] C1  = 32'h0000_1400;
  logic clk = 1'b0, rst_b = 1'b0, done = 1'b0, asst = 1'b0, sec = 1'b0;
  logic req, rvalid, swake, idle, fail;
  logic [31:0] vec = VEC, addr, rdata;
  logic [127:0] words = 128'h0;
  logic [1:0] wt = 2'h0;
  logic [2:0] wake;
  logic [95:0] start;
  int n_mismatch = 0, n_checks = 0;
  brw_boot_wake brw_boot_wake_inst (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_reset_seq_done(done), .i_cfg_boot_vector(vec), .i_cfg_assist_en(asst),
    .i_cfg_security_en(sec), .i_assist_base(32'h0000_1000), .i_assist_size(32'h0000_0100),
    .o_rd_req(req), .o_rd_addr(addr), .i_rd_data(rdata), .i_rd_valid(rvalid),
    .o_core_wake(wake), .o_core_start_addr(start), .o_security_wake(swake),
    .o_func_idle(idle), .o_boot_fail(fail));
  brw_flash_model brw_flash_model_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_rd_req(req),
    .i_rd_addr(addr), .i_words(words), .i_wait(wt), .o_rd_data(rdata), .o_rd_valid(rvalid));
  // ----------------------------------------
  // Clock, checks and closing
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset, load the record, release and wait for idle or fail
  task automatic boot(input logic a, input logic s, input logic [31:0] v,
                      input logic [127:0] w, input logic [1:0] d);
    @(posedge clk);
    rst_b <= 1'b0;
    done <= 1'b0;
    asst <= a;
    sec <= s;
    vec <= v;
    words <= w;
    wt <= d;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    done <= 1'b1;
    for (int k = 0; k < 80 && idle !== 1'b1 && fail !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_direct();
    boot(1'b0, 1'b1, VEC, {C1, C0, SA, 32'h00a5_0007}, 2'h0);
    chk("wake", wake, 3'h4);
    chk("start", start, {SA, 64'h0});
    chk("sec", swake, 1'b1);
    chk("idle", idle, 1'b1);
  endtask
  task automatic t_assist();
    logic [2:0] f;
    for (int i = 0; i < 4; i++) begin
      f = 3'(2 * i + 1);
      boot(1'b1, 1'b0, VEC, {C1, C0, SA, 29'h0014_a000, f}, 2'h2);
      chk("wake", wake, {1'b1, f[2], f[1]});
      chk("start", start, {SA, f[2] ? C1 : 32'h0, f[1] ? C0 : 32'h0});
      chk("sec", swake, 1'b0);
    end
  endtask
  task automatic t_bad(input logic a, input logic [31:0] v, input logic [31:0] tag);
    boot(a, 1'b0, v, {C1, C0, SA, tag}, 2'h1);
    chk("fail", fail, 1'b1);
    chk("wake", wake, 3'h0);
    chk("idle", idle, 1'b0);
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    t_direct();
    t_assist();
    t_bad(1'b0, VEC, 32'h00a4_0001);
    t_bad(1'b1, VEC, 32'h00a5_0009);
    t_bad(1'b0, 32'h0000_2000, 32'h00a5_0001);
    wrap_up();
  end
endmodule
`default_nettype wire
